// file: hw/lpc_mem_map.svh
// Constants for the low pin count memory cycle engine.
// Assumes inclusion by both ends; the bench does not include it.
`ifndef LPC_MEM_MAP_SVH
`define LPC_MEM_MAP_SVH
`define LPC_START 4'h0
`define LPC_ABORT 4'hF
`define LPC_SYNC_OK 4'h0
`define LPC_TAR 4'hF
`define LPC_TYPE_MEM 2'h1
`define LPC_TYPE_HI 3
`define LPC_TYPE_LO 2
`define LPC_TYPE_DIR 1
`define LPC_ADDR_NIBBLES 4'h8
`define LPC_ADDR_TOP 8'hFF
`define LPC_SPACE_BIT 22
`define LPC_STRAP_HI 23
`define LPC_STRAP_LO_HI 21
`define LPC_STRAP_LO_LO 19
`endif

// file: hw/lpc_mem_pkg.sv
// Types shared by both ends of the memory cycle engine.
// Assumes lpc_mem_map.svh for the numeric constants.
package lpc_mem_pkg;
   typedef logic [3:0] nibble_t;
   typedef logic [31:0] addr_t;
   typedef logic [7:0] byte_t;
endpackage

// file: hw/lpc_link_if.sv
// Link between host controller and flash target: clock shared, frame, nibble bus.
// Assumes the bench resolves the nibble bus from the two enables.
`timescale 1ns/1ps
interface lpc_link_if;
   logic frame_n;
   logic [3:0] host_lad_o;
   logic host_lad_oe;
   logic [3:0] dev_lad_o;
   logic dev_lad_oe;
   logic [3:0] lad_i;
   modport host (output frame_n, output host_lad_o, output host_lad_oe, input lad_i);
   modport dev (input frame_n, output dev_lad_o, output dev_lad_oe, input lad_i);
endinterface

// file: hw/lpc_mem_target.sv
// Flash side target engine for memory read and write cycles.
// Assumes frame and nibble bus synchronous to clk; array and registers sit outside.
`timescale 1ns/1ps
`include "lpc_mem_map.svh"
// Operation
// - Cycle starts: frame low with start nibble
// - Type nibble: 01 memory, bit1 direction
// - Act only on last start nibble
// - Eight address nibbles, most significant first
// - Space bit routes array or registers
// - Read: host turnaround, device drives clock 12
// - Read: sync zero at clock 13
// - Data byte low nibble then high
// - Write: host turnaround, device drives clock 14
// - Write: sync zero at clock 15
// - Write: device ones clock 16, releases
// - Frame low mid cycle terminates cycle
// - Abort nibble returns device to ready
// - Abort leaves internal write running
// - Invalid fields give no indication
// - Respond only inside decode range
// - Sample nibble bus on rising edge
// - Strap mismatch ignores rest of cycle
// - Host sets top address byte ones
// - Reset deselects and floats outputs
module lpc_mem_target (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   lpc_link_if.dev link,
   // Strap inputs
   input wire logic [3:0] strap_select_bits,
   // User side: access request
   output logic req,
   output logic req_write,
   output logic space_select_bit,
   output lpc_mem_pkg::addr_t req_addr,
   output lpc_mem_pkg::byte_t req_wdata,
   // User side: read data returned
   input wire lpc_mem_pkg::byte_t rdata
);
   // ************************************************************
   // Cycle states
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_TYPE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_WDAT = 4'b0011,
      ST_TAR0 = 4'b0100,
      ST_TAR1 = 4'b0101,
      ST_SYNC = 4'b0110,
      ST_RDAT = 4'b0111,
      ST_DTAR = 4'b1000,
      ST_ABRT = 4'b1001
   } state_e;

   state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic wr, next_wr;
   lpc_mem_pkg::addr_t addr, next_addr;
   lpc_mem_pkg::byte_t data, next_data;
   logic next_req;
   lpc_mem_pkg::nibble_t next_lad_o;
   logic next_lad_oe;

   // ************************************************************
   // Decode range match
   // ************************************************************
   function automatic logic hit(input lpc_mem_pkg::addr_t a, input logic [3:0] s);
      hit = (a[31:24] == `LPC_ADDR_TOP) && (a[`LPC_STRAP_HI] == ~s[3]) &&
         (a[`LPC_STRAP_LO_HI:`LPC_STRAP_LO_LO] == ~s[2:0]);
   endfunction

   // ************************************************************
   // Cycle sequencer
   // ************************************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_wr = wr;
      next_addr = addr;
      next_data = data;
      next_req = 1'b0;
      next_lad_o = `LPC_TAR;
      next_lad_oe = 1'b0;
      if (!link.frame_n) begin
         // Latest start nibble wins while frame stays low
         if (link.lad_i == `LPC_START) begin
            next_state = ST_TYPE;
         end else begin
            next_state = ST_ABRT;
         end
      end else begin
         case (state)
            ST_TYPE: begin
               // Bit 0 reserved, ignored
               if (link.lad_i[`LPC_TYPE_HI:`LPC_TYPE_LO] == `LPC_TYPE_MEM) begin
                  next_wr = link.lad_i[`LPC_TYPE_DIR];
                  next_cnt = 4'h0;
                  next_state = ST_ADDR;
               end else begin
                  next_state = ST_IDLE;
               end
            end
            ST_ADDR: begin
               next_addr = {addr[27:0], link.lad_i};
               next_cnt = cnt + 4'h1;
               if (cnt == `LPC_ADDR_NIBBLES - 4'h1) begin
                  if (!hit({addr[27:0], link.lad_i}, strap_select_bits)) begin
                     next_state = ST_IDLE;
                  end else if (wr) begin
                     next_cnt = 4'h0;
                     next_state = ST_WDAT;
                  end else begin
                     next_req = 1'b1;
                     next_state = ST_TAR0;
                  end
               end
            end
            ST_WDAT: begin
               next_data = {link.lad_i, data[7:4]};
               next_cnt = cnt + 4'h1;
               if (cnt == 4'h1) begin
                  next_req = 1'b1;
                  next_state = ST_TAR0;
               end
            end
            ST_TAR0: begin
               next_lad_oe = 1'b1;
               next_lad_o = `LPC_TAR;
               if (!wr) begin
                  next_data = rdata;
               end
               next_state = ST_TAR1;
            end
            ST_TAR1: begin
               next_lad_oe = 1'b1;
               next_lad_o = `LPC_SYNC_OK;
               next_state = ST_SYNC;
            end
            ST_SYNC: begin
               next_lad_oe = 1'b1;
               next_cnt = 4'h0;
               if (wr) begin
                  next_lad_o = `LPC_TAR;
                  next_state = ST_DTAR;
               end else begin
                  next_lad_o = data[3:0];
                  next_state = ST_RDAT;
               end
            end
            ST_RDAT: begin
               next_lad_oe = 1'b1;
               next_cnt = cnt + 4'h1;
               if (cnt == 4'h0) begin
                  next_lad_o = data[7:4];
               end else begin
                  next_lad_o = `LPC_TAR;
                  next_state = ST_DTAR;
               end
            end
            ST_DTAR: begin
               next_state = ST_IDLE;
            end
            ST_ABRT: begin
               // Internal write engine sits outside and is untouched
               next_state = ST_IDLE;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         addr <= 32'h00000000;
         data <= 8'h00;
         req <= 1'b0;
         link.dev_lad_o <= `LPC_TAR;
         link.dev_lad_oe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         wr <= next_wr;
         addr <= next_addr;
         data <= next_data;
         req <= next_req;
         link.dev_lad_o <= next_lad_o;
         link.dev_lad_oe <= next_lad_oe;
      end
   end

   // ************************************************************
   // User side outputs
   // ************************************************************
   assign req_write = wr;
   assign req_addr = addr;
   assign req_wdata = data;
   assign space_select_bit = addr[`LPC_SPACE_BIT];
endmodule

// file: hw/lpc_mem_host.sv
// Host controller end issuing one memory read or write cycle per request.
// Assumes the target end follows the fixed clock 11 to 17 timing.
`timescale 1ns/1ps
`include "lpc_mem_map.svh"
module lpc_mem_host (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   lpc_link_if.host link,
   // User side: command
   input wire logic start,
   input wire logic write,
   input wire lpc_mem_pkg::addr_t addr,
   input wire lpc_mem_pkg::byte_t wdata,
   input wire logic abort,
   output logic busy,
   // User side: result
   output logic done,
   output logic sync_ok,
   output lpc_mem_pkg::byte_t rdata
);
   logic [4:0] clk_no, next_clk_no;
   logic wr, next_wr;
   lpc_mem_pkg::addr_t a, next_a;
   lpc_mem_pkg::byte_t wd, next_wd, next_rdata;
   logic next_done, next_sync_ok, next_frame_n, next_oe;
   lpc_mem_pkg::nibble_t next_o;

   // ************************************************************
   // Cycle clock counter, 1 to 16
   // ************************************************************
   always_comb begin
      next_clk_no = clk_no;
      next_wr = wr;
      next_a = a;
      next_wd = wd;
      next_rdata = rdata;
      next_done = 1'b0;
      next_sync_ok = sync_ok;
      next_frame_n = 1'b1;
      next_oe = 1'b0;
      next_o = `LPC_TAR;
      if (abort && clk_no != 5'h0) begin
         next_frame_n = 1'b0;
         next_oe = 1'b1;
         next_o = `LPC_ABORT;
         next_clk_no = 5'h0;
      end else if (clk_no == 5'h0) begin
         if (start) begin
            next_wr = write;
            next_a = {`LPC_ADDR_TOP, addr[23:0]};
            next_wd = wdata;
            next_frame_n = 1'b0;
            next_oe = 1'b1;
            next_o = `LPC_START;
            next_clk_no = 5'h1;
         end
      end else begin
         next_clk_no = clk_no + 5'h1;
         case (clk_no)
            5'h1: begin
               next_oe = 1'b1;
               next_o = {`LPC_TYPE_MEM, wr, 1'b0};
            end
            5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9: begin
               next_oe = 1'b1;
               next_o = a[31:28];
               next_a = {a[27:0], 4'h0};
            end
            5'h0A: begin
               next_oe = 1'b1;
               next_o = wr ? wd[3:0] : `LPC_TAR;
            end
            5'h0B: begin
               next_oe = wr;
               next_o = wd[7:4];
            end
            5'h0C: begin
               next_oe = wr;
               next_o = `LPC_TAR;
            end
            5'h10: begin
               next_oe = 1'b1;
               next_o = `LPC_TAR;
               next_done = 1'b1;
               next_clk_no = 5'h0;
            end
            default: begin
               next_oe = 1'b0;
            end
         endcase
         // Sample target fields on the rising edge carrying them
         if (clk_no == 5'h0D) begin
            next_sync_ok = wr ? sync_ok : (link.lad_i == `LPC_SYNC_OK);
         end
         if (clk_no == 5'h0E && !wr) begin
            next_rdata[3:0] = link.lad_i;
         end
         if (clk_no == 5'h0F) begin
            if (wr) begin
               next_sync_ok = (link.lad_i == `LPC_SYNC_OK);
            end else begin
               next_rdata[7:4] = link.lad_i;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clk_no <= 5'h0;
         wr <= 1'b0;
         a <= 32'h00000000;
         wd <= 8'h00;
         rdata <= 8'h00;
         done <= 1'b0;
         sync_ok <= 1'b0;
         link.frame_n <= 1'b1;
         link.host_lad_oe <= 1'b0;
         link.host_lad_o <= `LPC_TAR;
      end else begin
         clk_no <= next_clk_no;
         wr <= next_wr;
         a <= next_a;
         wd <= next_wd;
         rdata <= next_rdata;
         done <= next_done;
         sync_ok <= next_sync_ok;
         link.frame_n <= next_frame_n;
         link.host_lad_oe <= next_oe;
         link.host_lad_o <= next_o;
      end
   end

   assign busy = (clk_no != 5'h0);
endmodule

// file: tb/lpc_link_assertions.sv
// Concurrent checks on the link that joins host and target ends.
// Assumes plain link signals from the bench top and one clock domain.
`timescale 1ns/1ps
module lpc_link_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   input wire logic frame_n,
   input wire logic [3:0] host_lad_o,
   input wire logic host_lad_oe,
   input wire logic [3:0] dev_lad_o,
   input wire logic dev_lad_oe,
   input wire logic [3:0] lad_i
);
   // ****************************************
   // Link checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   chk_one_driver: assert property (!(host_lad_oe && dev_lad_oe))
      else $error("both ends drive the bus");
   chk_tar_ones: assert property ($rose(dev_lad_oe) |-> dev_lad_o == 4'hF)
      else $error("target turnaround not all ones");
   chk_sync_next: assert property ($rose(dev_lad_oe) |=> dev_lad_o == 4'h0)
      else $error("sync not zero after turnaround");
   chk_drive_span: assert property ($rose(dev_lad_oe) ##0 frame_n [*2]
      |-> dev_lad_oe [*2])
      else $error("target drive too short");
   chk_release_ones: assert property ($fell(dev_lad_oe) && !$past(srst)
      |-> $past(dev_lad_o) == 4'hF)
      else $error("target released without ones");
   chk_frame_quiet: assert property (!frame_n |=> !dev_lad_oe)
      else $error("target drives after frame low");
   chk_start_quiet: assert property ((!frame_n && lad_i == 4'h0)
      |=> !dev_lad_oe [*8])
      else $error("target drives during header");
   chk_type_next: assert property ((!frame_n && lad_i == 4'h0)
      |=> frame_n && host_lad_oe && host_lad_o[3:2] == 2'h1)
      else $error("type nibble not memory");
   chk_host_tar: assert property ($fell(host_lad_oe) && !$past(srst)
      |-> $past(host_lad_o) == 4'hF)
      else $error("host released without ones");
   chk_reset_float: assert property ($fell(srst) |-> !dev_lad_oe && !host_lad_oe)
      else $error("driver on after reset");
   cov_start: cover property (!frame_n && lad_i == 4'h0);
   cov_abort: cover property (!frame_n && lad_i == 4'hF);
   cov_release: cover property ($fell(dev_lad_oe));
endmodule

// file: tb/tb_top.sv
// Self-checking bench: host and target ends joined by one link.
// Assumes the bench resolves the nibble bus, pull-up when nobody drives.
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic w; lpc_mem_pkg::addr_t a; lpc_mem_pkg::byte_t d; logic sp;} row_s;
   // ****************************************
   // Stimulus, ends and monitor
   // ****************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   logic write = 1'b0;
   logic abort = 1'b0;
   logic [3:0] strap = 4'h0;
   lpc_mem_pkg::addr_t addr = 32'h0;
   lpc_mem_pkg::byte_t wdata = 8'h00;
   lpc_mem_pkg::byte_t tdata = 8'h00;
   logic busy, done, sync_ok, req, req_write, space_select_bit, got_w, got_sp;
   lpc_mem_pkg::byte_t rdata, req_wdata, got_d;
   lpc_mem_pkg::addr_t req_addr, got_a;
   int failures = 0;
   int checks = 0;
   int reqs = 0;
   int dones = 0;
   int n, i, k;
   logic [4:0] cnt = 5'h0;
   logic [31:0] oem = 32'h0;
   logic [3:0] nib [32];
   wire [23:0] tail = {nib[11], nib[12], nib[13], nib[14], nib[15], nib[16]};
   row_s rows [4] = '{'{1'b0, 32'hFFF81234, 8'hA5, 1'b1}, '{1'b0, 32'hFFB80010, 8'h3C, 1'b0},
      '{1'b1, 32'hFFFFFFFF, 8'h5A, 1'b1}, '{1'b1, 32'hFFBFFFFF, 8'hC3, 1'b0}};
   always #5 clk = ~clk;
   lpc_link_if u_lpc_link_if ();
   wire [3:0] lad = u_lpc_link_if.host_lad_oe ? u_lpc_link_if.host_lad_o :
      u_lpc_link_if.dev_lad_oe ? u_lpc_link_if.dev_lad_o : 4'hF;
   assign u_lpc_link_if.lad_i = lad;
   wire dev_oe = u_lpc_link_if.dev_lad_oe;
   lpc_mem_host u_lpc_mem_host (.clk(clk), .srst(srst), .link(u_lpc_link_if), .start(start),
      .write(write), .addr(addr), .wdata(wdata), .abort(abort), .busy(busy), .done(done),
      .sync_ok(sync_ok), .rdata(rdata));
   lpc_mem_target u_lpc_mem_target (.clk(clk), .srst(srst), .link(u_lpc_link_if),
      .strap_select_bits(strap), .req(req), .req_write(req_write), .rdata(tdata),
      .space_select_bit(space_select_bit), .req_addr(req_addr), .req_wdata(req_wdata));
   lpc_link_assertions u_lpc_link_assertions (.clk(clk), .srst(srst),
      .frame_n(u_lpc_link_if.frame_n), .host_lad_o(u_lpc_link_if.host_lad_o),
      .host_lad_oe(u_lpc_link_if.host_lad_oe), .dev_lad_o(u_lpc_link_if.dev_lad_o),
      .dev_lad_oe(u_lpc_link_if.dev_lad_oe), .lad_i(u_lpc_link_if.lad_i));
   always @(posedge clk) begin
      if (req === 1'b1) begin
         reqs <= reqs + 1;
         got_w <= req_write;
         got_sp <= space_select_bit;
         got_a <= req_addr;
         got_d <= req_wdata;
      end
      if (done === 1'b1) begin
         dones <= dones + 1;
      end
      if (u_lpc_link_if.frame_n === 1'b0 && lad === 4'h0) begin
         cnt <= 5'h1;
         oem <= 32'h0;
      end else if (cnt != 5'h0 && cnt != 5'h1F) begin
         cnt <= cnt + 5'h1;
         oem[cnt + 5'h1] <= dev_oe;
         nib[cnt + 5'h1] <= lad;
      end
   end
   task automatic chk_bit(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t flag %b want %b", $time, g, e);
      end
   endtask
   task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t nibble %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t value %h want %h", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_idle;
      for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
      if (busy !== 1'b0) begin
         failures++;
         $display("[ERR] %0t wait timed out", $time);
         give_verdict();
      end
      @(negedge clk);
   endtask
   task automatic launch(input logic w, input lpc_mem_pkg::addr_t a, input lpc_mem_pkg::byte_t d);
      write = w;
      addr = a;
      wdata = d;
      tdata = d;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      srst = 1'b0;
      foreach (rows[r]) begin
         n = reqs;
         launch(rows[r].w, rows[r].a, rows[r].d);
         wait_idle();
         chk_val(reqs, n + 1);
         chk_val(dones, r + 1);
         chk_val(got_a, rows[r].a);
         chk_bit(got_w, rows[r].w);
         chk_bit(got_sp, rows[r].sp);
         chk_bit(sync_ok, 1'b1);
         chk_nib(nib[2] & 4'hE, {2'h1, rows[r].w, 1'b0});
         for (i = 0; i < 8; i++) chk_nib(nib[3 + i], rows[r].a[31 - 4 * i -: 4]);
         if (!rows[r].w) begin
            chk_val(rdata, rows[r].d);
            chk_val(oem, 32'h0001F000);
            chk_val({8'h0, tail},
               {20'h0FF0, rows[r].d[3:0], rows[r].d[7:4], 4'hF});
         end else begin
            chk_val(got_d, rows[r].d);
            chk_val(oem, 32'h0001C000);
            chk_val({8'h0, tail},
               {8'h0, rows[r].d[3:0], rows[r].d[7:4], 16'hFF0F});
         end
         $display("row %0d finished", r);
      end
      strap = 4'h1;
      n = reqs;
      launch(1'b0, rows[0].a, 8'h11);
      wait_idle();
      chk_val(reqs, n);
      chk_val(oem, 32'h0);
      chk_bit(sync_ok, 1'b0);
      strap = 4'h0;
      $display("strap mismatch finished");
      launch(1'b1, rows[2].a, 8'h77);
      repeat (4) @(negedge clk);
      abort = 1'b1;
      @(negedge clk);
      abort = 1'b0;
      wait_idle();
      chk_val(reqs, n);
      chk_val(dones, 5);
      chk_bit(dev_oe, 1'b0);
      launch(1'b0, rows[0].a, 8'h96);
      wait_idle();
      chk_val(reqs, n + 1);
      chk_val(dones, 6);
      chk_val(rdata, 8'h96);
      $display("abort finished");
      launch(1'b0, rows[0].a, 8'h69);
      for (k = 0; k < 20 && dev_oe !== 1'b1; k++) @(negedge clk);
      chk_bit(dev_oe, 1'b1);
      srst = 1'b1;
      @(negedge clk);
      chk_bit(dev_oe, 1'b0);
      chk_bit(busy, 1'b0);
      srst = 1'b0;
      @(negedge clk);
      $display("reset finished");
      give_verdict();
   end
endmodule
